// *** rtl/gpc_startup_cfg.v ***
// Startup configuration: bus address, power-on request and remote startup.
// Assumes rst is the power-on reset and reinit marks recovery from a supply dip.
//
// How it works
// R1: The bus address is the five address switches, msb switch on top and lsb switch at bit 0.
// R2: The installer sets an address of 0 to 30 only; all-ones is flagged as invalid here.
// R3: A closed switch reads as one and an open switch as zero.
// R4: The installer gives each bus device, and the controller, a distinct address.
// R5: With the option enabled a service request is raised after power-up and after re-init.
// R6: The request indicator lights whenever the power-on request has been raised.
// R7: A serial poll withdraws the request and turns off the request indicator.
// R8: Request option switch zero enables the power-on request, one disables it.
// R9: A startup switch chooses remote or local control at power-up.
// R10: With remote startup the remote indicator lights before any bus traffic is allowed.
// R11: Startup switch zero selects remote, one selects local.
// R12: Switches are sampled once on leaving reset or re-init and then held.
`include "gpc_cfg_defs.vh"
`default_nettype none
module gpc_startup_cfg #(
    parameter SETTLE_CYC = `GPC_SETTLE_CYC
) (
    input  wire                    clock,
    input  wire                    rst,
    input  wire                    reinit,
    input  wire [`GPC_SW_W-1:0]    rear_switch_bank,
    input  wire                    serial_poll,
    output reg  [`GPC_ADDR_W-1:0]  bus_addr,
    output reg                     addr_invalid,
    output reg                     power_on_request_enable,
    output reg                     startup_remote_select,
    output reg                     service_request,
    output reg                     request_indicator,
    output reg                     remote_indicator,
    output reg                     config_ready
);
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [15:0] cnt_reg;
    wire       load;
    wire [`GPC_SW_W-1:0] sw_q;

    // Sample at the end of settle so switch contacts seen right after reset are ignored
    assign load = (state_reg == `GPC_ST_SETTLE) && (cnt_reg == 16'h0000);

    gpc_sw_latch #(.W(`GPC_SW_W)) u_latch (
        .clock (clock),
        .rst   (rst),
        .load  (load),
        .sw_in (rear_switch_bank),
        .sw_q  (sw_q)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `GPC_ST_IDLE:   state_next = `GPC_ST_SETTLE;
            `GPC_ST_SETTLE: if (cnt_reg == 16'h0000) state_next = `GPC_ST_RUN;
            `GPC_ST_RUN:    if (reinit) state_next = `GPC_ST_SETTLE; // [R12]
            default:        state_next = `GPC_ST_IDLE;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= `GPC_ST_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (state_reg != `GPC_ST_SETTLE && state_next == `GPC_ST_SETTLE) begin
                cnt_reg <= SETTLE_CYC[15:0] - 16'h0001;
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end

    // Fields are decoded from the held copy, so they stay stable between samples [R12]
    wire [`GPC_ADDR_W-1:0] addr_w = sw_q[`GPC_SW_ADDR_MSB:`GPC_SW_ADDR_LSB]; // [R1]
    wire req_en_w = (sw_q[`GPC_SW_REQ_BIT] == `GPC_REQ_ENABLED);              // [R8]
    wire remote_w = (sw_q[`GPC_SW_REM_BIT] == `GPC_REM_REMOTE);               // [R9] [R11]
    reg  load_d;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            load_d                  <= 1'b0;
            bus_addr                <= 5'h00;
            addr_invalid            <= 1'b0;
            power_on_request_enable <= 1'b0;
            startup_remote_select   <= 1'b0;
            service_request         <= 1'b0;
            request_indicator       <= 1'b0;
            remote_indicator        <= 1'b0;
            config_ready            <= 1'b0;
        end else begin
            load_d <= load;
            if (load_d) begin
                bus_addr                <= addr_w;
                addr_invalid            <= (addr_w > `GPC_ADDR_MAX); // [R2]
                power_on_request_enable <= req_en_w;
                startup_remote_select   <= remote_w;
                // Indicator set with the fields, so it is lit once ready allows bus traffic [R10]
                remote_indicator        <= remote_w;
            end
            config_ready <= load_d || (config_ready && !(state_reg == `GPC_ST_RUN && reinit));
            // Request raised on each power-up or re-init when enabled; a poll in the same cycle loses
            // to the new request so the event is not dropped [R5] [R7]
            if (load_d && req_en_w) begin
                service_request   <= 1'b1; // [R5]
                request_indicator <= 1'b1; // [R6]
            end else if (serial_poll) begin
                service_request   <= 1'b0; // [R7]
                request_indicator <= 1'b0; // [R7]
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/gpc_cfg_defs.vh ***
// Constants for the startup configuration block.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef GPC_CFG_DEFS_VH
`define GPC_CFG_DEFS_VH
`define GPC_ADDR_W          5
`define GPC_ADDR_MAX        5'h1e
`define GPC_SW_W            7
`define GPC_SW_ADDR_LSB     0
`define GPC_SW_ADDR_MSB     4
`define GPC_SW_REQ_BIT      5
`define GPC_SW_REM_BIT      6
`define GPC_SW_ON           1'b1
`define GPC_REQ_ENABLED     1'b0
`define GPC_REM_REMOTE      1'b0
`define GPC_SETTLE_NS       1000
`define GPC_CLK_NS          20
`define GPC_SETTLE_CYC      ((`GPC_SETTLE_NS + `GPC_CLK_NS - 1) / `GPC_CLK_NS)
`define GPC_ST_IDLE         2'h0
`define GPC_ST_SETTLE       2'h1
`define GPC_ST_RUN          2'h2
`endif

// *** rtl/gpc_sw_latch.v ***
// Switch capture: samples the rear switch bank once on a load strobe.
// Assumes switch levels are already synchronous and debounced upstream.
`include "gpc_cfg_defs.vh"
`default_nettype none
module gpc_sw_latch #(
    parameter W = `GPC_SW_W
) (
    input  wire         clock,
    input  wire         rst,
    input  wire         load,
    input  wire [W-1:0] sw_in,
    output wire [W-1:0] sw_q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // One flop per switch keeps each bit of the bus with a single driver
            reg bit_reg;
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    bit_reg <= 1'b0;
                end else if (load) begin
                    // Closed switch reads one, open reads zero [R3]
                    bit_reg <= (sw_in[i] == `GPC_SW_ON);
                end
            end
            assign sw_q[i] = bit_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// *** bench/gpc_cfg_sva.sv ***
// Port checker for the startup configuration block, bound to its top module.
// Assumes switches stay still while a startup sample is being taken.
`default_nettype none
module gpc_cfg_sva (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       reinit,
    input wire logic       serial_poll,
    input wire logic       addr_invalid,
    input wire logic       config_ready,
    input wire logic       power_on_request_enable,
    input wire logic       startup_remote_select,
    input wire logic       service_request,
    input wire logic       request_indicator,
    input wire logic       remote_indicator,
    input wire logic [6:0] rear_switch_bank,
    input wire logic [4:0] bus_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_addr;
        $rose(config_ready) |-> bus_addr == $past(rear_switch_bank[4:0], 2);
    endproperty
    a_addr: assert property (p_addr) else $error("address not from switches");
    property p_inv;
        config_ready |-> addr_invalid == (bus_addr == 5'h1f);
    endproperty
    a_inv: assert property (p_inv) else $error("invalid flag wrong");
    property p_req;
        $rose(config_ready) |-> power_on_request_enable == !$past(rear_switch_bank[5], 2);
    endproperty
    a_req: assert property (p_req) else $error("request option wrong");
    property p_sel;
        $rose(config_ready) |-> startup_remote_select == !$past(rear_switch_bank[6], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("startup select wrong");
    property p_srq;
        $rose(config_ready) |-> service_request == !$past(rear_switch_bank[5], 2);
    endproperty
    a_srq: assert property (p_srq) else $error("power-on request wrong");
    property p_led;
        request_indicator == service_request;
    endproperty
    a_led: assert property (p_led) else $error("request indicator differs");
    property p_poll;
        service_request && serial_poll && !reinit && $past(config_ready) |=> !service_request;
    endproperty
    a_poll: assert property (p_poll) else $error("poll did not clear request");
    property p_rem;
        $rose(config_ready) |-> remote_indicator == !$past(rear_switch_bank[6], 2);
    endproperty
    a_rem: assert property (p_rem) else $error("remote indicator wrong");
    property p_hold;
        config_ready && $past(config_ready) |-> $stable(bus_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("address moved after sample");
    c_srq: cover property ($rose(config_ready) && service_request);
    c_poll: cover property (serial_poll && service_request);
    c_inv: cover property (config_ready && addr_invalid);
endmodule
bind gpc_startup_cfg gpc_cfg_sva chk_u (.clock, .rst, .reinit, .serial_poll, .addr_invalid,
    .config_ready, .power_on_request_enable, .startup_remote_select, .service_request,
    .request_indicator, .remote_indicator, .rear_switch_bank, .bus_addr);
`default_nettype wire

// *** bench/gpc_ctrl_model.sv ***
// Bus controller model: answers a pending request with a serial poll.
// Assumes it is clocked with the block and drives at the falling edge.
`default_nettype none
module gpc_ctrl_model (
    input  wire logic clock,
    input  wire logic service_request,
    output var  logic serial_poll
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt = 3'h0;
    initial serial_poll = 1'b0;
    // Polls late on purpose, so the request is seen standing first
    always @(negedge clock) begin
        serial_poll <= (service_request === 1'b1) && wait_cnt[2];
        wait_cnt <= (service_request === 1'b1) ? wait_cnt + 3'h1 : 3'h0;
    end
endmodule
`default_nettype wire

// *** bench/tb_gpc_startup_cfg.sv ***
// Bench for the startup block: four all-ones address banks, then random switch banks, across resets and re-inits.
// Assumes rtl/ on the include path.
`include "gpc_cfg_defs.vh"
`default_nettype none
module tb_gpc_startup_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, reinit = 0, serial_poll, addr_invalid, config_ready;
    logic pre, srs, srq, rqi, rmi;
    logic [`GPC_SW_W-1:0] sw = 7'h00;
    logic [4:0] bus_addr;
    logic [10:0] exp_q[$];
    logic [10:0] got;
    logic [4:0] exp_addr;
    // Controller's own bus address; no bank that is sampled is set to it
    localparam logic [4:0] ctrl_addr = 5'h00;
    int bad_count = 0, samples_checked = 0, k;
    initial forever #10 clock = ~clock;
    gpc_startup_cfg #(.SETTLE_CYC(2)) dut_u (.clock, .rst, .reinit, .rear_switch_bank(sw),
        .serial_poll, .bus_addr, .addr_invalid, .power_on_request_enable(pre),
        .startup_remote_select(srs), .service_request(srq), .request_indicator(rqi),
        .remote_indicator(rmi), .config_ready);
    gpc_ctrl_model ctrl_u (.clock, .service_request(srq), .serial_poll);
    task chk(input logic [10:0] seen, input logic [10:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("Compared %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Closed switch is one; option and startup bits are active at zero
    always @(posedge config_ready) begin
        #1 got = {bus_addr, addr_invalid, pre, srs, srq, rqi, rmi};
        chk(got, exp_q.pop_front());
    end
    initial begin
        k = $urandom(35941);
        repeat (20) @(negedge clock);
        for (int i = 0; i < 24; i++) begin
            sw = (i < 4) ? {i[1:0], 5'h1f} : 7'($urandom);
            if (sw[4:0] == ctrl_addr) sw[0] = 1'b1;
            exp_q.push_back({sw[4:0], &sw[4:0], !sw[5], !sw[6], !sw[5], !sw[5], !sw[6]});
            if (i % 2 == 1) reinit = 1'b1;
            else rst = 1'b1;
            @(negedge clock);
            {rst, reinit} = 2'b00;
            for (k = 0; k < 200 && config_ready !== 1'b1; k++) @(negedge clock);
            if (k == 200) begin
                bad_count++;
                break;
            end
            exp_addr = sw[4:0];
            sw = 7'($urandom);
            repeat (2) @(negedge clock);
            for (k = 0; k < 20 && srq !== 1'b0; k++) @(negedge clock);
            chk({9'h0, srq, rqi}, 11'h0);
            chk({6'h0, bus_addr}, {6'h0, exp_addr});
            if (k == 20) begin
                bad_count++;
                break;
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
